/* File: word_order_address_encoder.sv */
// word serializer and logical address encoder with serial transmitter
`timescale 1ns/1ns
// Operation
// - data words are 16 bits; low byte bits 00-07, high byte bits 10-17 octal
// - each word goes out as two bytes, low byte before high byte
// - every byte is transmitted least significant bit first, like a plain uart
// - bcd words hold digits 0-9 per nibble; codes above 9 are flagged invalid
// - hex words use full nibble range, 0 to ffff, no check needed
// - word address is doubled to a byte address, sent low byte first
// - extended address describes one to six memory levels
// - first byte is a flag byte; set bit means a level value follows
// - level values below ff go direct; ff and above follow an ff byte, low first
// - the last requested level always has its flag set and value sent
module word_order_address_encoder import word_order_pkg::*; #(
  parameter int BIT_CYCLES = CLK_HZ / BAUD_RATE
) (
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic in_valid, // request valid
  output logic in_ready, // request taken when high with in_valid
  input wire logic [1:0] in_kind, // data word, word address or extended address
  input wire logic [15:0] in_data, // data word or word address
  input wire logic in_bcd, // data word holds bcd digits
  input wire logic [5:0] in_flags, // levels requested, bit 0 is level 1
  input wire logic [2:0] in_depth, // last level wanted, 1 to 6
  input wire logic [95:0] in_levels, // level values, level 1 in low 16 bits
  output logic tx_line, // serial output, idles high
  output logic bcd_error, // one-cycle pulse: bcd word had a bad digit
  output logic busy // framer, buffer or transmitter still active
);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_LO = 3'b001, S_HI = 3'b010, S_FLAG = 3'b011,
    S_LVL = 3'b100, S_ELO = 3'b101, S_EHI = 3'b110
  } frame_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
  } tx_state_t;

  // =====================================================================
  // helpers
  function automatic logic [15:0] level_value(input logic [95:0] lv, input logic [2:0] idx);
    level_value = lv[idx * LEVEL_W +: LEVEL_W];
  endfunction
  function automatic logic [2:0] clamp_depth(input logic [2:0] d);
    clamp_depth = (d == 3'h0) ? 3'h1 : ((d > 3'(LEVELS)) ? 3'(LEVELS) : d);
  endfunction
  function automatic logic bcd_bad(input logic [15:0] w);
    bcd_bad = (w[3:0] > BCD_MAX) || (w[7:4] > BCD_MAX) || (w[11:8] > BCD_MAX) || (w[15:12] > BCD_MAX);
  endfunction

  // =====================================================================
  // framer
  frame_state_t state, next_state;
  logic [15:0] cur_word, next_cur_word;
  logic [5:0] flags, next_flags;
  logic [2:0] depth, next_depth;
  logic [2:0] lvl_idx, next_lvl_idx;
  logic [95:0] levels, next_levels;
  logic next_in_ready, next_bcd_error;
  logic push_valid, push_ready;
  logic [7:0] push_data;
  logic [15:0] cur_lvl;
  logic [2:0] dd;
  logic [5:0] dmask;
  logic take;

  assign take = in_valid && in_ready;
  assign cur_lvl = level_value(levels, lvl_idx);

  always_comb begin
    next_state = state;
    next_cur_word = cur_word;
    next_flags = flags;
    next_depth = depth;
    next_lvl_idx = lvl_idx;
    next_levels = levels;
    next_bcd_error = 1'b0;
    push_valid = 1'b0;
    push_data = 8'h00;
    dd = clamp_depth(in_depth);
    dmask = 6'((7'h01 << dd) - 7'h01);
    case (state)
      S_IDLE: begin
        if (take) begin
          next_lvl_idx = 3'h0;
          if (in_kind == KIND_EXT_ADDR) begin
            next_levels = in_levels;
            next_depth = dd;
            next_flags = (in_flags & dmask) | 6'(7'h01 << (dd - 3'h1));
            if (dd != 3'h1 && level_value(in_levels, 3'h0) == LVL1_DEFAULT) begin
              next_flags[0] = 1'b0;
            end
            next_state = S_FLAG;
          end else if (in_kind == KIND_WORD_ADDR) begin
            next_cur_word = {in_data[14:0], 1'b0};
            next_state = S_LO;
          end else begin
            next_cur_word = in_data;
            next_bcd_error = in_bcd && bcd_bad(in_data);
            next_state = S_LO;
          end
        end
      end
      S_LO: begin
        push_valid = 1'b1;
        push_data = cur_word[7:0];
        if (push_ready) begin
          next_state = S_HI;
        end
      end
      S_HI: begin
        push_valid = 1'b1;
        push_data = cur_word[15:8];
        if (push_ready) begin
          next_state = S_IDLE;
        end
      end
      S_FLAG: begin
        push_valid = 1'b1;
        push_data = {2'b00, flags};
        if (push_ready) begin
          next_state = S_LVL;
        end
      end
      S_LVL: begin
        if (lvl_idx == depth) begin
          next_state = S_IDLE;
        end else if (!flags[lvl_idx]) begin
          next_lvl_idx = 3'(lvl_idx + 1'b1);
        end else begin
          push_valid = 1'b1;
          push_data = (cur_lvl < 16'(ESC_BYTE)) ? cur_lvl[7:0] : ESC_BYTE;
          if (push_ready) begin
            if (cur_lvl < 16'(ESC_BYTE)) begin
              next_lvl_idx = 3'(lvl_idx + 1'b1);
            end else begin
              next_state = S_ELO;
            end
          end
        end
      end
      S_ELO: begin
        push_valid = 1'b1;
        push_data = cur_lvl[7:0];
        if (push_ready) begin
          next_state = S_EHI;
        end
      end
      S_EHI: begin
        push_valid = 1'b1;
        push_data = cur_lvl[15:8];
        if (push_ready) begin
          next_lvl_idx = 3'(lvl_idx + 1'b1);
          next_state = S_LVL;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    next_in_ready = (next_state == S_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= S_IDLE;
      cur_word <= 16'h0000;
      flags <= 6'h00;
      depth <= 3'h1;
      lvl_idx <= 3'h0;
      levels <= '0;
      in_ready <= 1'b0;
      bcd_error <= 1'b0;
    end else begin
      state <= next_state;
      cur_word <= next_cur_word;
      flags <= next_flags;
      depth <= next_depth;
      lvl_idx <= next_lvl_idx;
      levels <= next_levels;
      in_ready <= next_in_ready;
      bcd_error <= next_bcd_error;
    end
  end

  // =====================================================================
  // byte buffer
  logic pop_valid, pop_ready;
  logic [7:0] pop_data;

  word_order_buffer #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buffer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .s_valid(push_valid),
    .s_ready(push_ready),
    .s_data(push_data),
    .m_valid(pop_valid),
    .m_ready(pop_ready),
    .m_data(pop_data)
  );

  // =====================================================================
  // serial transmitter: start bit, eight data bits lsb first, stop bit
  tx_state_t tx_state, next_tx_state;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_byte, next_tx_byte;
  logic next_tx_line, next_busy;

  assign pop_ready = (tx_state == TX_IDLE);

  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt = (tx_cnt != 16'h0000) ? 16'(tx_cnt - 1'b1) : tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_byte = tx_byte;
    next_tx_line = tx_line;
    case (tx_state)
      TX_IDLE: begin
        next_tx_line = 1'b1;
        if (pop_valid) begin
          next_tx_byte = pop_data;
          next_tx_line = 1'b0;
          next_tx_cnt = BIT_LAST;
          next_tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tx_cnt == 16'h0000) begin
          next_tx_bit = 3'h0;
          next_tx_line = tx_byte[0];
          next_tx_cnt = BIT_LAST;
          next_tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_cnt == 16'h0000) begin
          next_tx_cnt = BIT_LAST;
          if (tx_bit == 3'h7) begin
            next_tx_line = 1'b1;
            next_tx_state = TX_STOP;
          end else begin
            next_tx_bit = 3'(tx_bit + 1'b1);
            next_tx_line = tx_byte[3'(tx_bit + 1'b1)];
          end
        end
      end
      TX_STOP: begin
        if (tx_cnt == 16'h0000) begin
          next_tx_state = TX_IDLE;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
    next_busy = (next_state != S_IDLE) || pop_valid || push_valid || (next_tx_state != TX_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'h0;
      tx_byte <= 8'h00;
      tx_line <= 1'b1;
      busy <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_byte <= next_tx_byte;
      tx_line <= next_tx_line;
      busy <= next_busy;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_word_bytes;
    state == S_HI |-> push_data == cur_word[15:8];
  endproperty
  a_word_bytes: assert property (p_word_bytes) else $error("high byte not bits 10-17");
  property p_low_first;
    state == S_LO && push_ready |=> state == S_HI;
  endproperty
  a_low_first: assert property (p_low_first) else $error("high byte did not follow low byte");
  property p_lsb_first;
    tx_state == TX_DATA |-> tx_line == tx_byte[tx_bit];
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("serial bit order wrong");
  property p_bcd_flag;
    take && in_kind == KIND_DATA && in_bcd && in_data[3:0] > BCD_MAX |=> bcd_error;
  endproperty
  a_bcd_flag: assert property (p_bcd_flag) else $error("bad bcd digit not flagged");
  property p_hex_word;
    take && in_kind == KIND_DATA |=> cur_word == $past(in_data) && state == S_LO;
  endproperty
  a_hex_word: assert property (p_hex_word) else $error("data word not captured");
  property p_addr_double;
    take && in_kind == KIND_WORD_ADDR |=> cur_word == {$past(in_data[14:0]), 1'b0};
  endproperty
  a_addr_double: assert property (p_addr_double) else $error("byte address not doubled");
  property p_depth_bound;
    state == S_FLAG |-> depth >= 3'h1 && depth <= 3'(LEVELS) && (flags >> depth) == 6'h00;
  endproperty
  a_depth_bound: assert property (p_depth_bound) else $error("level beyond depth flagged");
  property p_flag_first;
    state == S_FLAG |-> push_data == {2'b00, flags} && push_valid;
  endproperty
  a_flag_first: assert property (p_flag_first) else $error("flag byte not sent first");
  property p_escape;
    state == S_LVL && push_valid && cur_lvl >= 16'(ESC_BYTE) |-> push_data == ESC_BYTE;
  endproperty
  a_escape: assert property (p_escape) else $error("two-byte value missing delimiter");
  property p_last_flag;
    state == S_FLAG |-> flags[3'(depth - 3'h1)];
  endproperty
  a_last_flag: assert property (p_last_flag) else $error("last level flag clear");

  c_data_word: cover property (state == S_HI && push_ready);
  c_escape: cover property (state == S_EHI && push_ready);
  c_buffer_full: cover property (push_valid && !push_ready);
  c_bcd_bad: cover property (bcd_error);
endmodule

/* File: word_order_pkg.sv */
// constants shared by the word order and address encoder
package word_order_pkg;
  // request kinds
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_WORD_ADDR = 2'h1;
  localparam logic [1:0] KIND_EXT_ADDR = 2'h2;
  // extended address layout
  localparam int LEVELS = 6;
  localparam int LEVEL_W = 16;
  localparam logic [7:0] ESC_BYTE = 8'hff;
  localparam logic [15:0] LVL1_DEFAULT = 16'h0003;
  // digit limits
  localparam logic [3:0] BCD_MAX = 4'h9;
  // serial timing
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BUF_DEPTH = 2;
endpackage

/* File: word_order_buffer.sv */
// small valid/ready buffer between the byte framer and the serial transmitter
`timescale 1ns/1ns
module word_order_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic s_valid, // write side valid
  output logic s_ready, // write side ready
  input wire logic [WIDTH-1:0] s_data, // write side data
  output logic m_valid, // read side valid
  input wire logic m_ready, // read side ready
  output logic [WIDTH-1:0] m_data // read side data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign s_ready = (count != CW'(DEPTH));
  assign m_valid = (count != '0);
  assign m_data = mem[rd_ptr];
  assign push = s_valid && s_ready;
  assign pop = m_valid && m_ready;

  always_comb begin
    next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= s_data;
    end
  end
endmodule

/* File: word_order_host.sv */
// serial host model that receives the bytes sent by the encoder's transmitter
`timescale 1ns/1ns
module word_order_host #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic tx_line // serial line from the device
);
  logic [7:0] got[$];
  logic [7:0] mem[0:63];
  logic [7:0] b;
  int n_rx = 0;
  int stop_errs = 0;
  // ==========================================
  // receiver: start bit, eight data bits, stop bit
  // the line is looked at on falling edges, away from the edge that launches it
  initial begin
    forever begin
      @(negedge clk_sys);
      if (tx_line === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(negedge clk_sys);
          b[i] = tx_line;
        end
        repeat (BIT_CYCLES) @(negedge clk_sys);
        if (tx_line !== 1'b1) begin
          stop_errs++;
        end
        got.push_back(b);
        // swapped store, every word starting on an even byte
        mem[(n_rx ^ 1) % 64] = b;
        n_rx++;
      end
    end
  end
endmodule

/* File: word_order_address_encoder_bench.sv */
// self-checking bench for the word order and address encoder
`timescale 1ns/1ns
module word_order_address_encoder_bench;
  import word_order_pkg::*;
  localparam int BITC = 4;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [1:0] in_kind = 2'h0;
  logic [15:0] in_data = 16'h0000;
  logic in_bcd = 1'b0;
  logic [5:0] in_flags = 6'h00;
  logic [2:0] in_depth = 3'h1;
  logic [95:0] in_levels = 96'h0;
  logic tx_line;
  logic bcd_error;
  logic busy;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  word_order_address_encoder #(.BIT_CYCLES(BITC)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .in_valid(in_valid),
    .in_ready(in_ready), .in_kind(in_kind), .in_data(in_data), .in_bcd(in_bcd), .in_flags(in_flags),
    .in_depth(in_depth), .in_levels(in_levels), .tx_line(tx_line), .bcd_error(bcd_error), .busy(busy));
  word_order_host #(.BIT_CYCLES(BITC)) i_host (.clk_sys(clk_sys), .tx_line(tx_line));

  // ==========================================
  // clock and hang guard
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================
  // shared tasks
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one request held until taken; counts bcd_error cycles afterwards
  task automatic send(input logic [1:0] kind, input logic [15:0] data, input logic bcd, input logic [5:0] flags,
                      input logic [2:0] depth, input logic [95:0] levels, input int exp_pulses);
    int k;
    int p;
    @(negedge clk_sys);
    in_kind = kind;
    in_data = data;
    in_bcd = bcd;
    in_flags = flags;
    in_depth = depth;
    in_levels = levels;
    in_valid = 1'b1;
    k = 0;
    // ready is looked at on the falling edge, before the rising edge that takes the request
    while (in_ready !== 1'b1 && k < 1000) begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    in_valid = 1'b0;
    chk("ready after take", 16'h0000, {15'h0, in_ready});
    p = 0;
    repeat (4) begin
      if (bcd_error === 1'b1) p++;
      @(negedge clk_sys);
    end
    chk("bcd pulses", exp_pulses[15:0], p[15:0]);
  endtask

  task automatic expect_bytes(input logic [7:0] exp[$]);
    int k;
    k = 0;
    while (i_host.got.size() < exp.size() && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("byte count", 16'(exp.size()), 16'(i_host.got.size()));
    foreach (exp[i]) chk("serial byte", {8'h00, exp[i]}, {8'h00, i_host.got[i]});
    i_host.got.delete();
    k = 0;
    while (busy !== 1'b0 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    chk("busy", 16'h0000, {15'h0, busy});
    chk("idle line", 16'h0001, {15'h0, tx_line});
  endtask

  // ==========================================
  // scenarios
  task automatic t_data;
    send(KIND_DATA, 16'h1234, 1'b0, 6'h00, 3'h1, 96'h0, 0);
    send(KIND_DATA, 16'hffff, 1'b0, 6'h00, 3'h1, 96'h0, 0);
    send(2'h3, 16'h00a5, 1'b0, 6'h00, 3'h1, 96'h0, 0);
    expect_bytes('{8'h34, 8'h12, 8'hff, 8'hff, 8'ha5, 8'h00});
    chk("swapped store", 16'h1234, {i_host.mem[0], i_host.mem[1]});
  endtask

  task automatic t_bcd;
    send(KIND_DATA, 16'h0239, 1'b1, 6'h00, 3'h1, 96'h0, 0);
    send(KIND_DATA, 16'h9999, 1'b1, 6'h00, 3'h1, 96'h0, 0);
    send(KIND_DATA, 16'h12a4, 1'b1, 6'h00, 3'h1, 96'h0, 1);
    send(KIND_DATA, 16'ha000, 1'b0, 6'h00, 3'h1, 96'h0, 0);
    expect_bytes('{8'h39, 8'h02, 8'h99, 8'h99, 8'ha4, 8'h12, 8'h00, 8'ha0});
  endtask

  task automatic t_addr;
    send(KIND_WORD_ADDR, 16'h0010, 1'b0, 6'h00, 3'h1, 96'h0, 0);
    send(KIND_WORD_ADDR, 16'h1234, 1'b0, 6'h00, 3'h1, 96'h0, 0);
    expect_bytes('{8'h20, 8'h00, 8'h68, 8'h24});
  endtask

  task automatic t_ext;
    send(KIND_EXT_ADDR, 16'h0, 1'b0, 6'h34, 3'h6,
         {16'h0000, 16'h0104, 16'h0000, 16'h0007, 16'h0000, 16'h0000}, 0);
    expect_bytes('{8'h34, 8'h07, 8'hff, 8'h04, 8'h01, 8'h00});
    send(KIND_EXT_ADDR, 16'h0, 1'b0, 6'h00, 3'h1, {80'h0, LVL1_DEFAULT}, 0);
    send(KIND_EXT_ADDR, 16'h0, 1'b0, 6'h03, 3'h2, {64'h0, 16'h00ff, LVL1_DEFAULT}, 0);
    send(KIND_EXT_ADDR, 16'h0, 1'b0, 6'h3f, 3'h1, {80'h0, 16'h0005}, 0);
    expect_bytes('{8'h01, 8'h03, 8'h02, 8'hff, 8'hff, 8'h00, 8'h01, 8'h05});
    send(KIND_EXT_ADDR, 16'h0, 1'b0, 6'h01, 3'h0, {80'h0, 16'h0009}, 0);
    send(KIND_EXT_ADDR, 16'h0, 1'b0, 6'h00, 3'h7, {16'h0012, 80'h0}, 0);
    expect_bytes('{8'h01, 8'h09, 8'h20, 8'h12});
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    chk("reset outputs", 16'h0004, {12'h0, in_ready, tx_line, bcd_error, busy});
    rstn = 1'b1;
    @(negedge clk_sys);
    chk("ready after reset", 16'h0001, {15'h0, in_ready});
    t_data();
    t_bcd();
    t_addr();
    t_ext();
    chk("stop bits", 16'h0000, i_host.stop_errs[15:0]);
    end_sim();
  end
endmodule
